// File: inc/scrb_pkg.sv
// Package of register map, field layout, reset values and serial port constants for the sync control bank.
package scrb_pkg;

	// Register offsets on the serial port.
	localparam logic [7:0] OFS_SYNC_SRC  = 8'h12;
	localparam logic [7:0] OFS_SEP_THR   = 8'h13;
	localparam logic [7:0] OFS_SCAN_POL  = 8'h14;
	localparam logic [7:0] OFS_POL_STAT  = 8'h15;
	localparam logic [7:0] OFS_SLICER    = 8'h16;
	localparam logic [7:0] OFS_LEAD      = 8'h17;
	localparam logic [7:0] OFS_TRAIL     = 8'h18;
	localparam logic [7:0] OFS_TEST_A    = 8'h19;
	localparam logic [7:0] OFS_TEST_B    = 8'h1a;
	localparam logic [7:0] OFS_TEST_C    = 8'h1b;
	localparam logic [7:0] OFS_FMT       = 8'h1c;
	localparam logic [7:0] OFS_MAX       = 8'h1d;

	// Field positions.
	localparam int BIT_PWR_N      = 0;
	localparam int BIT_COAST_SEL  = 1;
	localparam int BIT_VS_SEL     = 2;
	localparam int BIT_VS_OVR     = 3;
	localparam int BIT_HPOL_OVR   = 0;
	localparam int BIT_CPOL_OVR   = 1;
	localparam int BIT_SCAN_EN    = 2;
	localparam int BIT_HPOL_STAT  = 7;
	localparam int BIT_VPOL_STAT  = 6;
	localparam int BIT_CPOL_STAT  = 5;
	localparam int BIT_FMT        = 1;
	localparam int SLICER_LSB     = 3;

	// Reset values.
	localparam logic [7:0] RST_SYNC_SRC = 8'h01;
	localparam logic [7:0] RST_SEP_THR  = 8'h20;
	localparam logic [7:0] RST_SCAN_POL = 8'h00;
	localparam logic [7:0] RST_SLICER   = 8'hb8;
	localparam logic [7:0] RST_LEAD     = 8'h00;
	localparam logic [7:0] RST_TRAIL    = 8'h00;
	localparam logic [7:0] RST_TEST_A   = 8'h00;
	localparam logic [7:0] RST_TEST_B   = 8'h00;
	localparam logic [7:0] RST_TEST_C   = 8'h00;
	localparam logic [7:0] RST_FMT      = 8'h00;

	// Fixed upper bits of the serial slave address.
	localparam logic [4:0] SLAVE_HI = 5'h13;

	// Serial engine states.
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK} scrb_state_t;

endpackage : scrb_pkg

// File: hdl/scrb_bank.sv
// Sync control register bank with its two-wire serial slave port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Coast select bit routes coast pin or vsync.
// - Active-low power-down bit, resets to one.
// - Eight-bit separator threshold, resets to 32.
// - Scan enable bit, resets to zero.
// - Coast polarity override bit, resets zero.
// - Hsync polarity override bit, resets zero.
// - Status bit seven shows hsync polarity.
// - Status bit six shows vsync polarity.
// - Status bit five shows coast polarity.
// - Five-bit slicer threshold, resets to 23.
// - Pre-coast count of hsync periods, resets zero.
// - Post-coast count of hsync periods, resets zero.
// - Format bit picks 4:4:4 or 4:2:2.
// - In 4:2:2 green is luma, blue floats.
// - Up to four devices, distinct addresses.
// - Data changes only while clock low.
// - Start is data falling while clock high.
// - First byte: seven address bits, direction.
// - Address 10011 plus pins; ack on ninth.
// - Start, slave, register, data, stop order.
// - Bytes move most significant bit first.
// - Address increments, saturates at 1Dh.
// - Read follows written base via restart.
// - Stop is data rising while clock high.
//////////////////////////////////////////////////////////////////////////////
module scrb_bank (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [1:0] address_select_pins,
	input  wire logic       hsync_pol_det,
	input  wire logic       vsync_pol_det,
	input  wire logic       coast_pol_det,
	output logic            full_power_down_n,
	output logic            coast_src_vsync,
	output logic            vsync_src_override,
	output logic            vsync_src_separator,
	output logic [7:0]      sep_threshold,
	output logic            scan_enable,
	output logic            coast_pol_user,
	output logic            hsync_pol_user,
	output logic [4:0]      green_embedded_sync_thr,
	output logic [7:0]      coast_lead,
	output logic [7:0]      coast_trail,
	output logic            format_422,
	output logic            blue_out_oe_n
);

	//////////////////////////////////////////////////////////////////////////
	// Input synchronisers.
	logic [1:0] scl_sync_reg;  // Two-flop chain for the clock line.
	logic [1:0] sda_sync_reg;  // Two-flop chain for the data line.
	logic       scl_d_reg;     // Previous synced clock sample.
	logic       sda_d_reg;     // Previous synced data sample.
	logic [2:0] pol_s1_reg;    // First stage for polarity inputs.
	logic [2:0] pol_s2_reg;    // Second stage for polarity inputs.
	logic [1:0] sel_s1_reg;    // First stage for the address select pins.
	logic [1:0] sel_s2_reg;    // Second stage for the address select pins.

	// Both lines pass two flops; edges use the second stage only.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
			pol_s1_reg   <= 3'h0;
			pol_s2_reg   <= 3'h0;
			sel_s1_reg   <= 2'h0;
			sel_s2_reg   <= 2'h0;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
			pol_s1_reg   <= {hsync_pol_det, vsync_pol_det, coast_pol_det};
			pol_s2_reg   <= pol_s1_reg;
			sel_s1_reg   <= address_select_pins;
			sel_s2_reg   <= sel_s1_reg;
		end
	end

	// Edge and condition decode from synchronised samples.
	wire scl_s     = scl_sync_reg[1];
	wire sda_s     = sda_sync_reg[1];
	wire scl_rise  = scl_s & ~scl_d_reg;
	wire scl_fall  = ~scl_s & scl_d_reg;
	// Data moving while the clock is high marks start or stop.
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	//////////////////////////////////////////////////////////////////////////
	// Register storage.
	logic [7:0] regs_reg [8'h12:8'h1c];  // Writable bank, status slot unused.
	logic [7:0] base_reg;                // Current register pointer.

	// Status word built from detected polarities.
	wire [7:0] status_word = {pol_s2_reg, 5'h00};

	// Readable value at the pointer; outside the map reads zero.
	wire        ptr_in_map = (base_reg >= scrb_pkg::OFS_SYNC_SRC) && (base_reg <= scrb_pkg::OFS_FMT);
	wire [7:0]  rd_word    = (base_reg == scrb_pkg::OFS_POL_STAT) ? status_word :
	                         ptr_in_map ? regs_reg[base_reg] : 8'h00;

	//////////////////////////////////////////////////////////////////////////
	// Serial engine.
	scrb_pkg::scrb_state_t state_reg;  // Current phase.
	scrb_pkg::scrb_state_t ret_reg;    // Phase to enter after ack.
	logic [3:0]  bit_cnt_reg;          // Bits moved in the current byte.
	logic [7:0]  shift_reg;            // Receive or transmit shifter.
	logic        ack_ok_reg;           // Ack to drive in the ack slot.
	logic        wr_en_pulse;          // Data byte write strobe.

	// Address match on fixed bits plus select pins.
	wire addr_hit  = (shift_reg[7:3] == scrb_pkg::SLAVE_HI) &&
	                 (shift_reg[2:1] == sel_s2_reg);
	// Pointer advance with saturation at the top.
	wire [7:0] base_inc = (base_reg >= scrb_pkg::OFS_MAX) ? scrb_pkg::OFS_MAX : base_reg + 8'h01;

	// Byte engine: sample on rise, drive on fall, MSB first.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg   <= scrb_pkg::ST_IDLE;
			ret_reg     <= scrb_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			ack_ok_reg  <= 1'b0;
			base_reg    <= 8'h00;
			sda_out     <= 1'b0;
			sda_oe      <= 1'b0;
			wr_en_pulse <= 1'b0;
		end
		else
		begin
			wr_en_pulse <= 1'b0;
			if (start_det)
			begin
				// Start or repeated start re-arms the address phase.
				state_reg   <= scrb_pkg::ST_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe      <= 1'b0;
			end
			else if (stop_det)
			begin
				state_reg <= scrb_pkg::ST_IDLE;
				sda_oe    <= 1'b0;
			end
			else
			begin
				case (state_reg)
					scrb_pkg::ST_ADDR, scrb_pkg::ST_REG, scrb_pkg::ST_WDATA:
					begin
						if (scl_rise)
						begin
							shift_reg   <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (scl_fall && bit_cnt_reg == 4'h8)
						begin
							// Decide the ack after the eighth bit.
							bit_cnt_reg <= 4'h0;
							state_reg   <= scrb_pkg::ST_ACK;
							if (state_reg == scrb_pkg::ST_ADDR)
							begin
								ack_ok_reg <= addr_hit;
								ret_reg    <= !addr_hit ? scrb_pkg::ST_IDLE :
								              shift_reg[0] ? scrb_pkg::ST_RDATA : scrb_pkg::ST_REG;
							end
							else if (state_reg == scrb_pkg::ST_REG)
							begin
								// Base above the top is refused.
								ack_ok_reg <= (shift_reg <= scrb_pkg::OFS_MAX);
								ret_reg    <= (shift_reg <= scrb_pkg::OFS_MAX) ? scrb_pkg::ST_WDATA : scrb_pkg::ST_IDLE;
								if (shift_reg <= scrb_pkg::OFS_MAX)
								begin
									base_reg <= shift_reg;
								end
							end
							else
							begin
								ack_ok_reg  <= 1'b1;
								ret_reg     <= scrb_pkg::ST_WDATA;
								wr_en_pulse <= 1'b1;
							end
							sda_out <= 1'b0;
							sda_oe  <= (state_reg == scrb_pkg::ST_WDATA) ? 1'b1 :
							           (state_reg == scrb_pkg::ST_ADDR) ? addr_hit : (shift_reg <= scrb_pkg::OFS_MAX);
						end
					end
					scrb_pkg::ST_ACK:
					begin
						// Release after the ninth pulse; load read data if reading.
						if (scl_fall)
						begin
							state_reg <= ret_reg;
							sda_oe    <= 1'b0;
							if (ret_reg == scrb_pkg::ST_RDATA)
							begin
								shift_reg   <= {rd_word[6:0], 1'b0};
								sda_out     <= 1'b0;
								sda_oe      <= ~rd_word[7];
								bit_cnt_reg <= 4'h1;
							end
						end
					end
					scrb_pkg::ST_RDATA:
					begin
						// Shift out on each fall; open drain drives lows only.
						if (scl_fall)
						begin
							if (bit_cnt_reg == 4'h8)
							begin
								sda_oe      <= 1'b0;
								state_reg   <= scrb_pkg::ST_RACK;
								base_reg    <= base_inc;
								bit_cnt_reg <= 4'h0;
							end
							else
							begin
								sda_oe      <= ~shift_reg[7];
								shift_reg   <= {shift_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					scrb_pkg::ST_RACK:
					begin
						// Master ack continues; nack ends the read.
						if (scl_rise)
						begin
							ret_reg <= sda_s ? scrb_pkg::ST_IDLE : scrb_pkg::ST_RDATA;
						end
						else if (scl_fall)
						begin
							state_reg <= ret_reg;
							if (ret_reg == scrb_pkg::ST_RDATA)
							begin
								shift_reg   <= {rd_word[6:0], 1'b0};
								sda_oe      <= ~rd_word[7];
								bit_cnt_reg <= 4'h1;
							end
						end
					end
					default:
					begin
						sda_oe <= 1'b0;
					end
				endcase
			end
			// A written byte advances the pointer once it is stored.
			if (wr_en_pulse)
			begin
				base_reg <= base_inc;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register writes; status slot and out-of-map pointer drop the byte.
	localparam logic [7:0] RST_VAL [8'h12:8'h1c] = '{scrb_pkg::RST_SYNC_SRC, scrb_pkg::RST_SEP_THR,
		scrb_pkg::RST_SCAN_POL, 8'h00, scrb_pkg::RST_SLICER, scrb_pkg::RST_LEAD, scrb_pkg::RST_TRAIL,
		scrb_pkg::RST_TEST_A, scrb_pkg::RST_TEST_B, scrb_pkg::RST_TEST_C, scrb_pkg::RST_FMT};

	genvar gi;
	generate
		for (gi = 8'h12; gi <= 8'h1c; gi++)
		begin : g_reg
			// One storage word per offset.
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					regs_reg[gi] <= RST_VAL[gi];
				end
				else if (wr_en_pulse && base_reg == 8'(gi) && 8'(gi) != scrb_pkg::OFS_POL_STAT)
				begin
					regs_reg[gi] <= shift_reg;
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Registered control outputs toward the sync and output logic.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			full_power_down_n       <= 1'b1;
			coast_src_vsync         <= 1'b0;
			vsync_src_override      <= 1'b0;
			vsync_src_separator     <= 1'b0;
			sep_threshold           <= scrb_pkg::RST_SEP_THR;
			scan_enable             <= 1'b0;
			coast_pol_user          <= 1'b0;
			hsync_pol_user          <= 1'b0;
			green_embedded_sync_thr <= scrb_pkg::RST_SLICER[7:3];
			coast_lead              <= 8'h00;
			coast_trail             <= 8'h00;
			format_422              <= 1'b0;
			blue_out_oe_n           <= 1'b0;
		end
		else
		begin
			full_power_down_n       <= regs_reg[scrb_pkg::OFS_SYNC_SRC][scrb_pkg::BIT_PWR_N];
			coast_src_vsync         <= regs_reg[scrb_pkg::OFS_SYNC_SRC][scrb_pkg::BIT_COAST_SEL];
			vsync_src_override      <= regs_reg[scrb_pkg::OFS_SYNC_SRC][scrb_pkg::BIT_VS_OVR];
			vsync_src_separator     <= regs_reg[scrb_pkg::OFS_SYNC_SRC][scrb_pkg::BIT_VS_SEL];
			sep_threshold           <= regs_reg[scrb_pkg::OFS_SEP_THR];
			scan_enable             <= regs_reg[scrb_pkg::OFS_SCAN_POL][scrb_pkg::BIT_SCAN_EN];
			coast_pol_user          <= regs_reg[scrb_pkg::OFS_SCAN_POL][scrb_pkg::BIT_CPOL_OVR];
			hsync_pol_user          <= regs_reg[scrb_pkg::OFS_SCAN_POL][scrb_pkg::BIT_HPOL_OVR];
			green_embedded_sync_thr <= regs_reg[scrb_pkg::OFS_SLICER][7:scrb_pkg::SLICER_LSB];
			coast_lead              <= regs_reg[scrb_pkg::OFS_LEAD];
			coast_trail             <= regs_reg[scrb_pkg::OFS_TRAIL];
			format_422              <= regs_reg[scrb_pkg::OFS_FMT][scrb_pkg::BIT_FMT];
			blue_out_oe_n           <= regs_reg[scrb_pkg::OFS_FMT][scrb_pkg::BIT_FMT];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks.

	// A start always reopens the address phase, even in the middle of a byte.
	a_start_to_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		start_det |=> state_reg == scrb_pkg::ST_ADDR) else $error("start did not open address phase");

	// A stop returns the engine to idle and lets go of the data line.
	a_stop_to_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		stop_det && !start_det |=> state_reg == scrb_pkg::ST_IDLE && !sda_oe) else $error("stop not honoured");

	// The pointer never goes past its saturation slot.
	a_ptr_saturate: assert property (@(posedge core_clk) disable iff (!rst_n)
		base_reg <= scrb_pkg::OFS_MAX) else $error("pointer past top");

	// An engine that stays idle must not hold the line low.
	a_no_drive_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_reg == scrb_pkg::ST_IDLE && $past(state_reg) == scrb_pkg::ST_IDLE |-> !sda_oe) else $error("drive while idle");

	// Status bits trail the detector pins by the two synchroniser stages.
	a_status_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
		base_reg == scrb_pkg::OFS_POL_STAT |-> rd_word[7] == $past(hsync_pol_det, 2) &&
		rd_word[6] == $past(vsync_pol_det, 2) && rd_word[5] == $past(coast_pol_det, 2) && rd_word[4:0] == 5'h00)
		else $error("status layout wrong");

	// The power control output trails its register bit by one cycle.
	a_power_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
		##1 full_power_down_n == $past(regs_reg[scrb_pkg::OFS_SYNC_SRC][0])) else $error("power bit lag");

	// A stored byte moves the pointer on by exactly one below the top.
	a_write_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en_pulse && base_reg < scrb_pkg::OFS_MAX |=> base_reg == $past(base_reg) + 8'h01) else $error("no increment");

	// The blue float control trails the format bit by one cycle.
	a_fmt_blue: assert property (@(posedge core_clk) disable iff (!rst_n)
		##1 blue_out_oe_n == $past(regs_reg[scrb_pkg::OFS_FMT][scrb_pkg::BIT_FMT])) else $error("blue float mismatch");

	// Ninth clock falling in an ack slot that is not followed by read data.
	sequence s_ack_slot_end;
		state_reg == scrb_pkg::ST_ACK ##0 scl_fall && !start_det && !stop_det && ret_reg != scrb_pkg::ST_RDATA;
	endsequence

	// The ack pull is let go once the ninth clock falls.
	a_ack_release: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_ack_slot_end |=> !sda_oe) else $error("ack slot not released");

	// Throughout the ack slot the line pull matches the ack decision.
	a_ack_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_reg == scrb_pkg::ST_ACK |-> sda_oe == ack_ok_reg) else $error("ack drive differs from decision");

endmodule : scrb_bank

// File: test/scrb_master_model.sv
// Two-wire serial bus master model that drives the serial port of the sync control bank.
`timescale 1ns/1ps
module scrb_master_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_line
);
	// Quarter of the 125 ns serial clock period.
	localparam realtime QTR = 31.25;

	//////////////////////////////////////////////////////////////////////////////
	// Idle bus: SCL stands high and SDA is released to its pull-up.
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Opens a frame from idle, or a repeated start from the middle of a frame.
	task automatic start_cond();
		sda_low = 1'b0;
		#QTR;
		scl = 1'b1;
		#QTR;
		sda_low = 1'b1;
		#(2 * QTR);
		scl = 1'b0;
		#QTR;
	endtask : start_cond

	// Closes a frame; SDA rises while SCL is high and the bus is left idle.
	task automatic stop_cond();
		sda_low = 1'b1;
		#QTR;
		scl = 1'b1;
		#QTR;
		sda_low = 1'b0;
		#(4 * QTR);
	endtask : stop_cond

	// One bit: SDA moves only while SCL is low and is sampled in mid-high.
	task automatic put_bit(input logic b, output logic seen);
		sda_low = ~b;
		#QTR;
		scl = 1'b1;
		#QTR;
		seen = sda_line;
		#QTR;
		scl = 1'b0;
		#QTR;
	endtask : put_bit

	// Eight bits most significant first, then the ninth (acknowledge) bit.
	task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_seen);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			put_bit(tx[i], s);
			rx[i] = s;
		end
		put_bit(ack_in, ack_seen);
	endtask : xfer_byte
endmodule : scrb_master_model

// File: test/scrb_bank_tb_top.sv
// Self-checking testbench of the sync control bank through its serial port.
`timescale 1ns/1ps
module scrb_bank_tb_top;
	logic       core_clk;     // System clock.
	logic       rst_n;        // Asynchronous reset, active low.
	logic [1:0] asel;         // Address select pin level.
	logic [2:0] det;          // Detected hsync, vsync, coast polarities.
	logic       scl;          // Serial clock from the master.
	logic       sda_low;      // Master pulls SDA low.
	logic       sda_out;      // Device data level when driving.
	logic       sda_oe;       // Device pulls SDA.
	logic       pwr_n, c_vs, vs_ovr, vs_sep, scan, cpol, hpol, f422, blue_n;
	logic [7:0] thr, lead, trail;
	logic [4:0] slicer;
	logic [7:0] wbuf [13];    // Bytes of a write burst.
	logic [7:0] rbuf [13];    // Bytes of a read burst.
	logic [7:0] etab [13];    // Expected read values.
	int         bad_count;
	int         tests_run;
	// Open-drain line with pull-up: low while any party pulls it.
	wire        sda_line = ~(sda_low | (sda_oe & ~sda_out));

	//////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock.
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	scrb_master_model u_master (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));

	scrb_bank u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.address_select_pins(asel), .hsync_pol_det(det[2]), .vsync_pol_det(det[1]), .coast_pol_det(det[0]),
		.full_power_down_n(pwr_n), .coast_src_vsync(c_vs), .vsync_src_override(vs_ovr),
		.vsync_src_separator(vs_sep), .sep_threshold(thr), .scan_enable(scan), .coast_pol_user(cpol),
		.hsync_pol_user(hpol), .green_embedded_sync_thr(slicer), .coast_lead(lead), .coast_trail(trail),
		.format_422(f422), .blue_out_oe_n(blue_n)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Compares one value and counts the outcome.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	// Writes n bytes of wbuf from a base address; acks are expected up to 1Ch.
	task automatic wr_burst(input logic [7:0] base, input int n);
		logic [7:0] rx;
		logic       ak;
		u_master.start_cond();
		u_master.xfer_byte({scrb_pkg::SLAVE_HI, asel, 1'b0}, 1'b1, rx, ak);
		check({7'h0, ak}, 8'h00);
		u_master.xfer_byte(base, 1'b1, rx, ak);
		check({7'h0, ak}, 8'h00);
		for (int i = 0; i < n; i++)
		begin
			u_master.xfer_byte(wbuf[i], 1'b1, rx, ak);
			if (base + i <= 8'h1c)
				check({7'h0, ak}, 8'h00);
		end
		u_master.stop_cond();
	endtask : wr_burst

	// Sets the base, restarts for reading and reads n bytes; the last one is refused.
	task automatic rd_burst(input logic [7:0] base, input int n);
		logic [7:0] rx;
		logic       ak;
		u_master.start_cond();
		u_master.xfer_byte({scrb_pkg::SLAVE_HI, asel, 1'b0}, 1'b1, rx, ak);
		u_master.xfer_byte(base, 1'b1, rx, ak);
		u_master.start_cond();
		u_master.xfer_byte({scrb_pkg::SLAVE_HI, asel, 1'b1}, 1'b1, rx, ak);
		check({7'h0, ak}, 8'h00);
		for (int i = 0; i < n; i++)
			u_master.xfer_byte(8'hff, (i == n - 1), rbuf[i], ak);
		u_master.stop_cond();
	endtask : rd_burst

	// Sends one slave address and, with use_b2, a second byte b2; compares the last ack and closes the frame.
	task automatic probe(input logic [7:0] b1, input logic use_b2, input logic [7:0] b2, input logic exp_nak);
		logic [7:0] rx;
		logic       ak;
		u_master.start_cond();
		u_master.xfer_byte(b1, 1'b1, rx, ak);
		if (use_b2)
			u_master.xfer_byte(b2, 1'b1, rx, ak);
		check({7'h0, ak}, {7'h0, exp_nak});
		u_master.stop_cond();
	endtask : probe

	//////////////////////////////////////////////////////////////////////////////
	// Bounded run: a hang counts as a mismatch.
	initial
	begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		final_report();
	end

	//////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		bad_count = 0;
		tests_run = 0;
		rst_n = 1'b0;
		asel = 2'b01;
		det = 3'b101;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		// Reset levels at the control outputs.
		check({4'h0, vs_ovr, vs_sep, c_vs, pwr_n}, 8'h01);
		check(thr, 8'h20);
		check({5'h0, scan, cpol, hpol}, 8'h00);
		check({3'h0, slicer}, 8'h17);
		check(lead | trail, 8'h00);
		check({6'h0, f422, blue_n}, 8'h00);
		// Reset values of the whole map read back in one burst.
		etab = '{8'h01, 8'h20, 8'h00, 8'ha0, 8'hb8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		rd_burst(8'h12, 11);
		for (int i = 0; i < 11; i++)
			check(rbuf[i], etab[i]);
		// Burst over every register and past the top; the status write is dropped.
		wbuf = '{8'h02, 8'h55, 8'h07, 8'hff, 8'h00, 8'hc1, 8'h0e, 8'h00, 8'h41, 8'h10, 8'hbe, 8'h99, 8'h66};
		wr_burst(8'h12, 13);
		check({4'h0, vs_ovr, vs_sep, c_vs, pwr_n}, 8'h02);
		check(thr, 8'h55);
		check({5'h0, scan, cpol, hpol}, 8'h07);
		check({3'h0, slicer}, 8'h00);
		check(lead, 8'hc1);
		check(trail, 8'h0e);
		check({6'h0, f422, blue_n}, 8'h03);
		etab = '{8'h02, 8'h55, 8'h07, 8'ha0, 8'h00, 8'hc1, 8'h0e, 8'h00, 8'h41, 8'h10, 8'hbe, 8'h00, 8'h00};
		rd_burst(8'h12, 13);
		for (int i = 0; i < 13; i++)
			check(rbuf[i], etab[i]);
		// Vsync source bits and power back on.
		wbuf[0] = 8'h0d;
		wr_burst(8'h12, 1);
		check({4'h0, vs_ovr, vs_sep, c_vs, pwr_n}, 8'h0d);
		// Every detector pattern shows in the status register.
		for (int p = 0; p < 8; p++)
		begin
			@(negedge core_clk);
			det = p[2:0];
			rd_burst(8'h15, 1);
			check(rbuf[0], {p[2:0], 5'h00});
		end
		// Only the address matching the select pins is acknowledged.
		for (int s = 0; s < 4; s++)
		begin
			@(negedge core_clk);
			asel = s[1:0];
			for (int a = 0; a < 4; a++)
				probe({scrb_pkg::SLAVE_HI, a[1:0], 1'b0}, 1'b0, 8'h00, (a != s));
			probe({5'h0c, s[1:0], 1'b0}, 1'b0, 8'h00, 1'b1);
		end
		// Base address at the top is taken, one above it is refused.
		probe({scrb_pkg::SLAVE_HI, asel, 1'b0}, 1'b1, 8'h1d, 1'b0);
		probe({scrb_pkg::SLAVE_HI, asel, 1'b0}, 1'b1, 8'h1e, 1'b1);
		final_report();
	end
endmodule : scrb_bank_tb_top
